//--- bench/ptdio_far_model.sv
// far side: pulse source, gate lines and bit lines of a device under test
// assumes the bench sets its levels; open lines sit at their pull level
`timescale 1ns/1ps
module ptdio_far_model (
    // lines from the design
    input  wire logic [15:0] pin_drv_i,
    input  wire logic [15:0] pin_oe_i,
    // lines into the design
    output logic             pulse_o,
    output logic             gate_o,
    output logic             gate_n_o,
    output logic [15:0]      pin_o
);
    logic        pulse_lvl = 1'b0;
    logic [1:0]  g_con     = 2'b00;
    logic [1:0]  g_lvl     = 2'b00;
    logic [15:0] ext_val   = 16'h0000;
    logic [15:0] ext_en    = 16'h0000;
    assign pulse_o  = pulse_lvl;
    assign gate_o   = g_con[0] ? g_lvl[0] : 1'b1;
    assign gate_n_o = g_con[1] ? g_lvl[1] : 1'b0;
    // released bit lines pulled up
    assign pin_o = (pin_oe_i & pin_drv_i) | (~pin_oe_i & ((ext_en & ext_val) | ~ext_en));
    task automatic pulses(input int n, input int half);
        repeat (n)
        begin
            #(half);
            pulse_lvl = 1'b1;
            #(half);
            pulse_lvl = 1'b0;
        end
    endtask
endmodule // ptdio_far_model

//--- bench/ptdio_properties.sv
// assertions on the register bus, port pins and interrupt of ptdio_top
// assumes binding into ptdio_top with clk_en_i held high
`timescale 1ns/1ps
module ptdio_properties
    import ptdio_pkg::*;
(
    // clock and reset
    input wire logic              core_clk_i,
    input wire logic              resetn_i,
    // register bus
    input wire logic              s_axi_awready,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    // pins and interrupt
    input wire logic [15:0]       port_pin_i,
    input wire logic [15:0]       port_pin_o,
    input wire logic [15:0]       port_pin_oe_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_write_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while answer pending");
    a_chan_numbers: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_CHAN_ID
        |=> s_axi_rdata == {8'h00, CH_ACCUM, CH_PORT_B, CH_PORT_A})
        else $error("channel numbers wrong");
    a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2b
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_port_in_read: assert property (($stable(port_pin_i) && $stable(port_pin_oe_o)) [*6] ##0
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_PORT_IN) |=> s_axi_rdata[15:0] ==
        (($past(port_pin_i) & ~$past(port_pin_oe_o)) | ($past(port_pin_o) & $past(port_pin_oe_o))))
        else $error("port read wrong");
    a_irq_cleared: assert property ($fell(irq_o) |-> $past(s_axi_bvalid) || s_axi_bvalid)
        else $error("interrupt fell without a write");
endmodule // ptdio_properties

bind ptdio_top ptdio_properties ptdio_properties_inst (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_pin_i(port_pin_i), .port_pin_o(port_pin_o), .port_pin_oe_o(port_pin_oe_o), .irq_o(irq_o)
);

//--- bench/tb.sv
// self-checking bench for ptdio_top with far-side model and bus tasks
// assumes the checker binds itself; clk_en_i and wstrb held constant
`timescale 1ns/1ps
module tb;
    import ptdio_pkg::*;
    logic              core_clk_i = 1'b0;
    logic              resetn_i   = 1'b0;
    logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]       s_axi_wdata  = 32'h0, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic              s_axi_bready = 1'b0, s_axi_rready = 1'b0, scan_strobe_i = 1'b0;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic              pulse, gate, gate_n, irq_o;
    logic [15:0]       pin_in, pin_out, pin_oe, dir, outv, ev, en;
    logic [3:0]        gc;
    int                n_mismatch = 0, comparisons = 0, exp_cnt = 1, exp_en, seed = 32'h98a1;
    always #10 core_clk_i = ~core_clk_i;
    ptdio_top ptdio_top_inst (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .scan_strobe_i(scan_strobe_i), .pulse_pin_i(pulse), .gate_pin_i(gate),
        .gate_n_pin_i(gate_n), .port_pin_i(pin_in), .port_pin_o(pin_out), .port_pin_oe_o(pin_oe), .irq_o(irq_o)
    );
    ptdio_far_model far_inst (
        .pin_drv_i(pin_out), .pin_oe_i(pin_oe), .pulse_o(pulse), .gate_o(gate), .gate_n_o(gate_n), .pin_o(pin_in)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_on;
        logic w_on;
        int t;
        @(posedge core_clk_i);
        aw_on = 1'b1;
        w_on = 1'b1;
        t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            t++;
            aw_on = aw_on && !s_axi_awready;
            w_on = w_on && !s_axi_wready;
            s_axi_awvalid <= aw_on;
            s_axi_wvalid <= w_on;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ar_on;
        int t;
        @(posedge core_clk_i);
        ar_on = 1'b1;
        t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk_i);
            t++;
            ar_on = ar_on && !s_axi_arready;
            s_axi_arvalid <= ar_on;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    task automatic irq_wait(input logic e);
        for (int t = 0; t < 20 && irq_o !== e; t++)
            @(posedge core_clk_i);
        chk({31'h0, irq_o}, {31'h0, e});
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        $display("unexpected at %0t: timeout", $time);
        results;
    end
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rchk(OFS_CTRL, CTRL_RST, RESP_OKAY);
        rchk(OFS_COUNT, 32'h0, RESP_OKAY);
        rchk(OFS_PORT_DIR, {16'h0, DIR_RST}, RESP_OKAY);
        rchk(OFS_CHAN_ID, {8'h00, CH_ACCUM, CH_PORT_B, CH_PORT_A}, RESP_OKAY);
        rchk(8'h2c, 32'h0, RESP_SLVERR);
        wchk(8'h30, 32'h1, RESP_SLVERR);
        $display("registers test done");
        for (int m = 0; m < 2; m++)
        begin
            wchk(OFS_CTRL, 32'(m) | 32'h2, RESP_OKAY);
            far_inst.pulse_lvl <= 1'b1;
            repeat (10) @(posedge core_clk_i);
            rchk(OFS_COUNT, 32'(1 - m), RESP_OKAY);
            far_inst.pulse_lvl <= 1'b0;
            repeat (10) @(posedge core_clk_i);
            rchk(OFS_COUNT, 32'h1, RESP_OKAY);
        end
        wchk(OFS_CTRL, 32'h0, RESP_OKAY);
        far_inst.pulses(4, 4999);
        exp_cnt += 4;
        repeat (10) @(posedge core_clk_i);
        rchk(OFS_COUNT, 32'(exp_cnt), RESP_OKAY);
        $display("edge test done");
        for (int i = 0; i < 7; i++)
        begin
            gc = (i < 4) ? {2'b11, 2'(i)} : (i == 4) ? 4'b0100 : (i == 5) ? 4'b1010 : 4'b0000;
            far_inst.g_con <= gc[3:2];
            far_inst.g_lvl <= gc[1:0];
            exp_en = (gc[2] ? gc[0] : 1) && !(gc[3] ? gc[1] : 0);
            repeat (8) @(posedge core_clk_i);
            far_inst.pulses(3, 73);
            exp_cnt += exp_en * 3;
            repeat (10) @(posedge core_clk_i);
            rchk(OFS_COUNT, 32'(exp_cnt), RESP_OKAY);
        end
        scan_strobe_i <= 1'b1;
        @(posedge core_clk_i);
        scan_strobe_i <= 1'b0;
        far_inst.pulses(2, 73);
        repeat (10) @(posedge core_clk_i);
        rchk(OFS_SNAP, 32'(exp_cnt), RESP_OKAY);
        rchk(OFS_COUNT, 32'(exp_cnt + 2), RESP_OKAY);
        $display("gate and scan test done");
        for (int k = 0; k < 4; k++)
        begin
            dir = {{8{k[1]}}, {8{k[0]}}};
            outv = 16'($random(seed));
            ev = 16'($random(seed));
            en = 16'($random(seed)) & ~dir;
            far_inst.ext_val <= ev;
            far_inst.ext_en <= en;
            wchk(OFS_PORT_DIR, {16'h0, dir}, RESP_OKAY);
            wchk(OFS_PORT_OUT, {16'h0, outv}, RESP_OKAY);
            repeat (8) @(posedge core_clk_i);
            chk({16'h0, pin_oe}, {16'h0, dir});
            chk({16'h0, pin_out & dir}, {16'h0, outv & dir});
            rchk(OFS_PORT_IN, {16'h0, (dir & outv) | (~dir & ((en & ev) | ~en))}, RESP_OKAY);
        end
        $display("port test done");
        far_inst.ext_en <= 16'h0000;
        wchk(OFS_PORT_DIR, 32'h0, RESP_OKAY);
        wchk(OFS_IRQ_STAT, 32'h7, RESP_OKAY);
        wchk(OFS_IRQ_MASK, 32'h3, RESP_OKAY);
        wchk(OFS_ALM_SEL, 32'h2c, RESP_OKAY);
        far_inst.ext_val <= 16'h0000;
        far_inst.ext_en <= 16'h1000;
        irq_wait(1'b1);
        rchk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        wchk(OFS_IRQ_MASK, 32'h0, RESP_OKAY);
        irq_wait(1'b0);
        wchk(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
        rchk(OFS_IRQ_STAT, 32'h0, RESP_OKAY);
        wchk(OFS_ALM_SEL, 32'h10, RESP_OKAY);
        wchk(OFS_ALM_PAT, 32'h0f00, RESP_OKAY);
        wchk(OFS_IRQ_MASK, 32'h2, RESP_OKAY);
        far_inst.ext_en <= 16'h1100;
        irq_wait(1'b1);
        rchk(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        wchk(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
        irq_wait(1'b0);
        $display("alarm test done");
        results;
    end
endmodule // tb

//--- core/ptdio_accum.sv
// pulse accumulator: gated edge counter with wrap
// assumes pulse and gate inputs already synchronised
`timescale 1ns/1ps
module ptdio_accum
    import ptdio_pkg::*;
(
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             resetn_i,
    input  wire logic             clk_en_i,
    // control
    input  wire logic             fall_edge_i,
    input  wire logic             clear_i,
    // synchronised inputs
    input  wire logic             pulse_i,
    input  wire logic             gate_i,
    input  wire logic             gate_n_i,
    // result
    output logic      [CNT_W-1:0] count_o,
    output logic                  wrap_o
);
    logic             prev_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic             wrap_reg;
    wire              rise    = pulse_i & ~prev_reg;
    wire              fall    = ~pulse_i & prev_reg;
    wire              edge_ok = fall_edge_i ? fall : rise;
    wire              gate_ok = gate_i & ~gate_n_i;
    wire              step    = edge_ok & gate_ok;
    wire              at_max  = (cnt_reg == CNT_MAX);

    assign cnt_next = at_max ? '0 : cnt_reg + 1'b1;

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prev_reg <= 1'b0;
            cnt_reg  <= '0;
            wrap_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            prev_reg <= pulse_i;
            wrap_reg <= step & at_max & ~clear_i;
            if (clear_i)
                cnt_reg <= '0;
            else if (step)
                cnt_reg <= cnt_next;
        end
    end

    assign count_o = cnt_reg;
    assign wrap_o  = wrap_reg;
endmodule // ptdio_accum

//--- core/ptdio_pkg.sv
// constants shared by the pulse totalizer and digital port block
// assumes a single 50 MHz core clock and an axi4-lite register master
//
// Contract
// - pulse accumulator counts every pulse up to the maximum counting rate
// - configuration picks rising or falling edge for counting
// - after reaching maximum count the next counted pulse wraps to zero
// - true gate high permits counting, low inhibits
// - inverted gate low permits counting, high inhibits
// - count only while both gates enable; either may be used alone
// - unconnected gate reads as enabling, so counting runs continuously
// - count readable on demand and sampled by a scan strobe
// - two independent 8-bit ports, each input or output
// - both ports usable together as one 16-bit word
// - selected input bit or pattern change raises an alarm, scan or not; pattern alarm here only if a pattern input bit then reads high
// - open input reads one through pull-up, grounded input reads zero
// - channel 01 and 02 are the ports, channel 03 the accumulator
package ptdio_pkg;
    localparam int          DATA_W         = 32;
    localparam int          ADDR_W         = 8;
    localparam int          CNT_W          = 26;
    localparam logic [25:0] CNT_MAX        = 26'h3ffffff;
    localparam int          PORT_W         = 8;
    localparam int          CLK_HZ         = 50_000_000;
    localparam int          MAX_RATE_HZ    = 100_000;
    localparam int          CYC_PER_PULSE  = CLK_HZ / MAX_RATE_HZ;
    // channel numbers
    localparam logic [7:0]  CH_PORT_A      = 8'h01;
    localparam logic [7:0]  CH_PORT_B      = 8'h02;
    localparam logic [7:0]  CH_ACCUM       = 8'h03;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_COUNT      = 8'h04;
    localparam logic [7:0]  OFS_SNAP       = 8'h08;
    localparam logic [7:0]  OFS_PORT_OUT   = 8'h0c;
    localparam logic [7:0]  OFS_PORT_DIR   = 8'h10;
    localparam logic [7:0]  OFS_PORT_IN    = 8'h14;
    localparam logic [7:0]  OFS_ALM_SEL    = 8'h18;
    localparam logic [7:0]  OFS_ALM_PAT    = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h20;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h24;
    localparam logic [7:0]  OFS_CHAN_ID    = 8'h28;
    // control fields
    localparam int          CTRL_FALL_BIT  = 0;
    localparam int          CTRL_CLR_BIT   = 1;
    localparam int          CTRL_PATM_BIT  = 2;
    // alarm select fields
    localparam int          ASEL_BIT_LSB   = 0;
    localparam int          ASEL_PEN_BIT   = 4;
    localparam int          ASEL_BEN_BIT   = 5;
    // status bits
    localparam int          ST_BIT_ALM     = 0;
    localparam int          ST_PAT_ALM     = 1;
    localparam int          ST_WRAP        = 2;
    localparam int          ST_W           = 3;
    // reset values
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
    localparam logic [15:0] DIR_RST        = 16'h0000;
    localparam logic [15:0] OUT_RST        = 16'hffff;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
endpackage

//--- core/ptdio_sync.sv
// three-stage synchroniser for a pin input
// assumes the pin is asynchronous to core_clk_i; change taken when stages 2 and 3 agree
`timescale 1ns/1ps
module ptdio_sync #(
    parameter int          W   = 1,
    parameter logic [63:0] RST = 64'h0
) (
    // clock and reset
    input  wire logic         core_clk_i,
    input  wire logic         resetn_i,
    input  wire logic         clk_en_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    initial
    begin
        if (W < 1 || W > 64) $error("ptdio_sync: width out of range");
    end

    genvar g;
    generate
        for (g = 0; g < W; g++)
        begin : g_bit
            assign out_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : out_reg[g];
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            s1_reg  <= RST[W-1:0];
            s2_reg  <= RST[W-1:0];
            s3_reg  <= RST[W-1:0];
            out_reg <= RST[W-1:0];
        end
        else if (clk_en_i)
        begin
            s1_reg  <= async_i;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_o = out_reg;
endmodule // ptdio_sync

//--- core/ptdio_top.sv
// top of pulse accumulator and parallel bit ports with axi4-lite registers
// assumes pins are asynchronous; gate pins pulled to their enabling level outside
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ptdio_top
    import ptdio_pkg::*;
(
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                resetn_i,
    input  wire logic                clk_en_i,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // axi4-lite write data
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // axi4-lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // scan sampling
    input  wire logic                scan_strobe_i,
    // accumulator pins
    input  wire logic                pulse_pin_i,
    input  wire logic                gate_pin_i,
    input  wire logic                gate_n_pin_i,
    // parallel bit ports, low byte first port
    input  wire logic [2*PORT_W-1:0] port_pin_i,
    output logic      [2*PORT_W-1:0] port_pin_o,
    output logic      [2*PORT_W-1:0] port_pin_oe_o,
    // interrupt
    output logic                     irq_o
);
    localparam int PW2 = 2 * PORT_W;

    // synchronised pins
    logic [2:0]     acc_sync;
    logic [PW2-1:0] port_sync;
    logic [CNT_W-1:0] count;
    logic             wrap;

    // registers
    logic [31:0]    ctrl_reg;
    logic [PW2-1:0] pout_reg;
    logic [PW2-1:0] pdir_reg;
    logic [31:0]    asel_reg;
    logic [PW2-1:0] apat_reg;
    logic [PW2-1:0] pin_prev_reg;
    logic [CNT_W-1:0] snap_reg;
    logic [ST_W-1:0]  stat_reg;
    logic [ST_W-1:0]  stat_next;
    logic [ST_W-1:0]  mask_reg;
    logic             clr_reg;
    logic             irq_reg;

    // bus state
    logic              awrdy_reg;
    logic              wrdy_reg;
    logic              arrdy_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              bvalid_reg;
    logic [1:0]        bresp_reg;
    logic              rvalid_reg;
    logic [1:0]        rresp_reg;
    logic [DATA_W-1:0] rdata_reg;

    initial
    begin
        if (PORT_W != 8) $error("ptdio_top: port width must be 8");
    end

    // open inputs idle high, gates idle enabling
    ptdio_sync #(.W(3), .RST(64'h2)) u_acc_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .clk_en_i   (clk_en_i),
        .async_i    ({gate_n_pin_i, gate_pin_i, pulse_pin_i}),
        .sync_o     (acc_sync)
    );

    ptdio_sync #(.W(PW2), .RST(64'hffff)) u_port_sync (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .clk_en_i   (clk_en_i),
        .async_i    (port_pin_i),
        .sync_o     (port_sync)
    );

    ptdio_accum u_accum (
        .core_clk_i  (core_clk_i),
        .resetn_i    (resetn_i),
        .clk_en_i    (clk_en_i),
        .fall_edge_i (ctrl_reg[CTRL_FALL_BIT]),
        .clear_i     (clr_reg),
        .pulse_i     (acc_sync[0]),
        .gate_i      (acc_sync[1]),
        .gate_n_i    (acc_sync[2]),
        .count_o     (count),
        .wrap_o      (wrap)
    );

    // port read-back: input bits from pins, output bits from latch
    wire [PW2-1:0] port_view = (port_sync & ~pdir_reg) | (pout_reg & pdir_reg);

    // alarm detection on input bits only
    wire [3:0]     sel_bit   = asel_reg[ASEL_BIT_LSB +: 4];
    wire [PW2-1:0] in_mask   = ~pdir_reg;
    wire [PW2-1:0] changed   = (port_sync ^ pin_prev_reg) & in_mask;
    wire           bit_alm   = asel_reg[ASEL_BEN_BIT] & changed[sel_bit];
    wire           pat_hit   = ((port_sync & apat_reg & in_mask) != 16'h0000);
    wire           pat_alm   = asel_reg[ASEL_PEN_BIT] & pat_hit
                               & ((changed & apat_reg) != 16'h0000);
    wire [ST_W-1:0] events   = {wrap, pat_alm, bit_alm};

    // write decode
    wire           wr_fire   = ~awrdy_reg & ~wrdy_reg & ~bvalid_reg;
    wire [7:0]     wa        = awaddr_reg & 8'hfc;
    wire           wr_ctrl   = wr_fire & (wa == OFS_CTRL);
    wire           wr_pout   = wr_fire & (wa == OFS_PORT_OUT);
    wire           wr_pdir   = wr_fire & (wa == OFS_PORT_DIR);
    wire           wr_asel   = wr_fire & (wa == OFS_ALM_SEL);
    wire           wr_apat   = wr_fire & (wa == OFS_ALM_PAT);
    wire           wr_stat   = wr_fire & (wa == OFS_IRQ_STAT);
    wire           wr_mask   = wr_fire & (wa == OFS_IRQ_MASK);
    wire           wr_known  = wr_ctrl | wr_pout | wr_pdir | wr_asel | wr_apat | wr_stat | wr_mask;
    wire [31:0]    bmask     = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire [31:0]    wmasked   = wdata_reg & bmask;
    wire           clr_req   = wr_ctrl & wmasked[CTRL_CLR_BIT];

    // status: set wins over clear
    assign stat_next = events | (stat_reg & ~(wr_stat ? wmasked[ST_W-1:0] : {ST_W{1'b0}}));

    // read decode
    wire [7:0]     ra        = s_axi_araddr & 8'hfc;
    wire           rd_fire   = s_axi_arvalid & ~rvalid_reg;
    wire           rd_known  = (ra <= OFS_CHAN_ID);
    wire [31:0]    rd_mux    =
        (ra == OFS_CTRL)     ? {29'h0, ctrl_reg[2:0]} :
        (ra == OFS_COUNT)    ? {6'h0, count} :
        (ra == OFS_SNAP)     ? {6'h0, snap_reg} :
        (ra == OFS_PORT_OUT) ? {16'h0, pout_reg} :
        (ra == OFS_PORT_DIR) ? {16'h0, pdir_reg} :
        (ra == OFS_PORT_IN)  ? {16'h0, port_view} :
        (ra == OFS_ALM_SEL)  ? {26'h0, asel_reg[5:0]} :
        (ra == OFS_ALM_PAT)  ? {16'h0, apat_reg} :
        (ra == OFS_IRQ_STAT) ? {29'h0, stat_reg} :
        (ra == OFS_IRQ_MASK) ? {29'h0, mask_reg} :
        (ra == OFS_CHAN_ID)  ? {8'h0, CH_ACCUM, CH_PORT_B, CH_PORT_A} :
                               32'h0;

    // axi handshake
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            awrdy_reg  <= 1'b1;
            wrdy_reg   <= 1'b1;
            arrdy_reg  <= 1'b1;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= '0;
        end
        else if (clk_en_i)
        begin
            if (s_axi_awvalid & awrdy_reg)
            begin
                awrdy_reg  <= 1'b0;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & wrdy_reg)
            begin
                wrdy_reg  <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg & s_axi_bready)
            begin
                bvalid_reg <= 1'b0;
                awrdy_reg  <= 1'b1;
                wrdy_reg   <= 1'b1;
            end
            arrdy_reg <= ~rd_fire & (arrdy_reg | s_axi_rready);
            if (rd_fire)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_mux;
                rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end
            else if (rvalid_reg & s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    // configuration and state registers
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_reg     <= CTRL_RST;
            pout_reg     <= OUT_RST;
            pdir_reg     <= DIR_RST;
            asel_reg     <= '0;
            apat_reg     <= '0;
            pin_prev_reg <= 16'hffff;
            snap_reg     <= '0;
            stat_reg     <= '0;
            mask_reg     <= '0;
            clr_reg      <= 1'b0;
            irq_reg      <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pin_prev_reg <= port_sync;
            stat_reg     <= stat_next;
            clr_reg      <= clr_req;
            irq_reg      <= |(stat_next & mask_reg);
            if (wr_ctrl)
                ctrl_reg <= {29'h0, wmasked[CTRL_PATM_BIT], 1'b0, wmasked[CTRL_FALL_BIT]};
            if (wr_pout)
                pout_reg <= (pout_reg & ~bmask[PW2-1:0]) | wmasked[PW2-1:0];
            if (wr_pdir)
                pdir_reg <= (pdir_reg & ~bmask[PW2-1:0]) | wmasked[PW2-1:0];
            if (wr_asel)
                asel_reg <= {26'h0, wmasked[5:0]};
            if (wr_apat)
                apat_reg <= wmasked[PW2-1:0];
            if (wr_mask)
                mask_reg <= wmasked[ST_W-1:0];
            if (scan_strobe_i)
                snap_reg <= count;
        end
    end

    // port drive; output registered
    logic [PW2-1:0] pin_o_reg;
    logic [PW2-1:0] pin_oe_reg;
    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_o_reg  <= OUT_RST;
            pin_oe_reg <= DIR_RST;
        end
        else if (clk_en_i)
        begin
            pin_o_reg  <= pout_reg;
            pin_oe_reg <= pdir_reg;
        end
    end

    assign s_axi_awready = awrdy_reg;
    assign s_axi_wready  = wrdy_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arrdy_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign port_pin_o    = pin_o_reg;
    assign port_pin_oe_o = pin_oe_reg;
    assign irq_o         = irq_reg;
endmodule // ptdio_top
